// ---- sdl_regs.vh ----
// Constants for the synthesizer divider and lock control block
`ifndef SDL_REGS_VH
`define SDL_REGS_VH

// Serial word and address decode
`define SDL_WORD_BITS       24
`define SDL_ADDR_FREQ       2'b00
`define SDL_ADDR_CFG        2'b01
`define SDL_ADDR_IFCUR      2'b10
// Frequency word fields
`define SDL_F_IFDEF         23
`define SDL_F_GPSSEL        22
`define SDL_F_LOCKEN        21
`define SDL_F_SPURCRL       20
`define SDL_F_MAIN_HI       19
`define SDL_F_MAIN_LO       16
`define SDL_F_SWAL_HI       15
`define SDL_F_SWAL_LO       13
`define SDL_F_NUM_HI        12
`define SDL_F_NUM_LO        2
// Configuration word fields
`define SDL_C_IFSEL_HI      23
`define SDL_C_IFSEL_LO      22
`define SDL_C_OSC           21
`define SDL_C_SPUR_HI       12
`define SDL_C_SPUR_LO       11
`define SDL_C_OUTLVL_HI     5
`define SDL_C_OUTLVL_LO     4
`define SDL_C_RFEN          3
`define SDL_C_IFEN          2
// IF current word field
`define SDL_IC_CUR_HI       23
`define SDL_IC_CUR_LO       22
// Bandwidth word fields
`define SDL_B_DUR_HI        23
`define SDL_B_DUR_LO        22
`define SDL_B_CRL_HI        21
`define SDL_B_CRL_LO        20
`define SDL_B_EN            19
// IF counter and IF reference word fields
`define SDL_I_SWAL_HI       16
`define SDL_I_SWAL_LO       13
`define SDL_I_MAIN_HI       12
`define SDL_I_MAIN_LO       4
`define SDL_I_REF_HI        13
`define SDL_I_REF_LO        5
// Reset values of the control words
`define SDL_RST_WORD        24'h000000
// Fraction denominators, one step per 10 kHz
`define SDL_DEN_1920        12'h780
`define SDL_DEN_1968        12'h7b0
// Default IF pairs and 120 kHz reference counts
`define SDL_DEF_MAIN_A      9'h0e5
`define SDL_DEF_SWAL_A      4'h9
`define SDL_DEF_MAIN_B      9'h058
`define SDL_DEF_SWAL_B      4'hf
`define SDL_DEF_MAIN_C      9'h0bf
`define SDL_DEF_SWAL_C      4'h4
`define SDL_DEF_REF_1920    9'h0a0
`define SDL_DEF_REF_1968    9'h0a4
// Lock detect timing
`define SDL_MCLK_PERIOD_NS  4
`define SDL_LOCK_WIN_NS     10
`define SDL_LOCK_WIN_CYC    ((`SDL_LOCK_WIN_NS) / (`SDL_MCLK_PERIOD_NS))
`define SDL_LOCK_GOOD       3'h4
`define SDL_CMP_LAST        6'h3f
// Spur reduction modes
`define SDL_SPUR_OFF        2'b00
`define SDL_SPUR_ONCE       2'b01

`endif

// ---- sdl_sync.v ----
// Two-stage synchroniser with rising edge detect for outside inputs
`timescale 1ns/1ns
`default_nettype none
module sdl_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_b,
    // Asynchronous inputs and their synchronised forms
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] level,
    output reg  [WIDTH-1:0] rise
);
    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] prev;

    // First stage feeds only the second stage
    always @(posedge clk) begin
        if (!rst_b) begin
            meta  <= {WIDTH{1'b0}};
            level <= {WIDTH{1'b0}};
            prev  <= {WIDTH{1'b0}};
            rise  <= {WIDTH{1'b0}};
        end else begin
            meta  <= din;
            level <= meta;
            prev  <= level;
            rise  <= level & ~prev;    // Edge taken after the second stage
        end
    end
endmodule // sdl_sync
`default_nettype wire

// ---- sdl_synth_ctrl.v ----
// Divider, power, serial load and lock detect control of the synthesizer
`timescale 1ns/1ns
`default_nettype none
`include "sdl_regs.vh"
module sdl_synth_ctrl #(
    parameter VARIANT_CELL = 1'b0       // 0 selects the PCS variant
) (
    // Clock and reset
    input  wire       MCLK,
    input  wire       RST_B,
    // Serial programming pins
    input  wire       SER_CLK,
    input  wire       SER_DATA,
    input  wire       LATCH_STROBE,
    // Power control pin
    input  wire       CHIP_ENABLE,
    // Reference and VCO inputs
    input  wire       REF_OSC_IN,
    input  wire       RF_VCO_IN,
    input  wire       IF_VCO_IN,
    // Section power state
    output reg        RF_SECTION_ON,
    output reg        IF_SECTION_ON,
    // Divider outputs, one-cycle pulses
    output reg        RF_REF_PULSE,
    output reg        RF_FB_PULSE,
    output reg        IF_REF_PULSE,
    output reg        IF_FB_PULSE,
    // Lock and acquisition
    output reg        LOCK_INDICATOR_OUT,
    output reg        WIDEBAND_ACTIVE,
    output reg  [1:0] WIDEBAND_CONTROL,
    output reg        SPUR_UPDATE,
    // Analog settings passed through
    output reg  [1:0] OUTPUT_LEVEL,
    output reg  [1:0] IF_PUMP_CURRENT
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    wire [6:0] pin_level;
    wire [6:0] pin_rise;
    sdl_sync #(
        .WIDTH (7)
    ) u_sync (
        .clk   (MCLK),
        .rst_b (RST_B),
        .din   ({IF_VCO_IN, RF_VCO_IN, REF_OSC_IN, CHIP_ENABLE,
                 LATCH_STROBE, SER_DATA, SER_CLK}),
        .level (pin_level),
        .rise  (pin_rise)
    );
    wire ser_clk_rise = pin_rise[0];
    wire ser_data     = pin_level[1];
    wire latch_rise   = pin_rise[2];
    wire ce           = pin_level[3];
    wire ref_rise     = pin_rise[4];
    wire rfvco_rise   = pin_rise[5];
    wire ifvco_rise   = pin_rise[6];

    ////////////////////////////////////////////////////////////////////////
    // Serial shift register and control words
    reg [23:0] shift;
    reg [23:0] frequency_word;
    reg [23:0] cfg_word;
    reg [23:0] ifcur_word;
    reg [23:0] bw_word;
    reg [23:0] ifcnt_word;
    reg [23:0] ifref_word;
    reg        freq_loaded;

    // Data taken on serial clock rise, MSB first
    always @(posedge MCLK) begin
        if (!RST_B) begin
            shift          <= `SDL_RST_WORD;
            frequency_word <= `SDL_RST_WORD;
            cfg_word       <= `SDL_RST_WORD;
            ifcur_word     <= `SDL_RST_WORD;
            bw_word        <= `SDL_RST_WORD;
            ifcnt_word     <= `SDL_RST_WORD;
            ifref_word     <= `SDL_RST_WORD;
            freq_loaded    <= 1'b0;
        end else begin
            freq_loaded <= 1'b0;
            if (ser_clk_rise) begin
                shift <= {shift[22:0], ser_data};
            end
            // Strobe rise moves the word to the addressed register
            if (latch_rise) begin
                if (shift[1:0] == `SDL_ADDR_FREQ) begin
                    frequency_word <= shift;
                    freq_loaded    <= 1'b1;
                end else if (shift[1:0] == `SDL_ADDR_CFG) begin
                    cfg_word <= shift;
                end else if (shift[1:0] == `SDL_ADDR_IFCUR) begin
                    ifcur_word <= shift;
                end else if (!shift[2]) begin
                    bw_word <= shift;
                end else if (!shift[3]) begin
                    ifcnt_word <= shift;
                end else if (!shift[4]) begin
                    ifref_word <= shift;
                end
            end
        end
    end

    // Field views
    wire        if_default  = frequency_word[`SDL_F_IFDEF];
    wire        gps_sel     = frequency_word[`SDL_F_GPSSEL];
    wire        lock_en     = frequency_word[`SDL_F_LOCKEN];
    wire [3:0]  rf_main_count     = frequency_word[`SDL_F_MAIN_HI:`SDL_F_MAIN_LO];
    wire [2:0]  rf_swallow_count  = frequency_word[`SDL_F_SWAL_HI:`SDL_F_SWAL_LO];
    wire [10:0] rf_frac_numerator = frequency_word[`SDL_F_NUM_HI:`SDL_F_NUM_LO];
    wire [1:0]  if_sel      = cfg_word[`SDL_C_IFSEL_HI:`SDL_C_IFSEL_LO];
    wire        osc_1968    = cfg_word[`SDL_C_OSC];
    wire [1:0]  spur_mode   = cfg_word[`SDL_C_SPUR_HI:`SDL_C_SPUR_LO];
    wire        rf_section_enable = cfg_word[`SDL_C_RFEN];
    wire        if_section_enable = cfg_word[`SDL_C_IFEN];
    wire [1:0]  wideband_duration = bw_word[`SDL_B_DUR_HI:`SDL_B_DUR_LO];
    wire [1:0]  wideband_control  = bw_word[`SDL_B_CRL_HI:`SDL_B_CRL_LO];
    wire        wideband_enable   = bw_word[`SDL_B_EN];

    ////////////////////////////////////////////////////////////////////////
    // Power gating
    wire rf_on = ce & rf_section_enable;
    wire if_on = ce & if_section_enable;

    ////////////////////////////////////////////////////////////////////////
    // RF feedback divider with first-order fraction accumulator
    wire        mod8    = (VARIANT_CELL == gps_sel);
    wire [6:0]  main_x  = mod8 ? {rf_main_count, 3'b000}
                               : ({2'b00, rf_main_count, 1'b0} + {1'b0, rf_main_count, 2'b00});
    reg  [10:0] frac_acc;
    reg         frac_carry;
    reg  [7:0]  rf_cnt;
    wire [7:0]  rf_n    = {1'b0, main_x} + {5'h00, rf_swallow_count}
                        + {7'h00, frac_carry};
    wire [11:0] den     = osc_1968 ? `SDL_DEN_1968 : `SDL_DEN_1920;
    wire [11:0] acc_sum = {1'b0, frac_acc} + {1'b0, rf_frac_numerator};
    wire        acc_ovf = (acc_sum >= den);
    wire [11:0] acc_sub = acc_sum - den;
    wire        rf_wrap = rfvco_rise && (rf_cnt + 8'h01 >= rf_n);

    // Each numerator step adds one VCO cycle per denominator divisions
    always @(posedge MCLK) begin
        if (!RST_B || !rf_on) begin
            rf_cnt     <= 8'h00;
            frac_acc   <= 11'h000;
            frac_carry <= 1'b0;
        end else if (rfvco_rise) begin
            if (rf_wrap) begin
                rf_cnt     <= 8'h00;
                frac_acc   <= acc_ovf ? acc_sub[10:0] : acc_sum[10:0];
                frac_carry <= acc_ovf;
            end else begin
                rf_cnt <= rf_cnt + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // IF dividers, programmed or default pairs
    reg  [8:0]  if_main;
    reg  [3:0]  if_swal;
    wire [8:0]  if_ref_n = if_default ? (osc_1968 ? `SDL_DEF_REF_1968 : `SDL_DEF_REF_1920)
                                      : ifref_word[`SDL_I_REF_HI:`SDL_I_REF_LO];

    // Default pair picked by the IF selection code
    always @* begin
        if (!if_default) begin
            if_main = ifcnt_word[`SDL_I_MAIN_HI:`SDL_I_MAIN_LO];
            if_swal = ifcnt_word[`SDL_I_SWAL_HI:`SDL_I_SWAL_LO];
        end else if (if_sel == 2'b10) begin
            if_main = `SDL_DEF_MAIN_A;
            if_swal = `SDL_DEF_SWAL_A;
        end else if (if_sel == 2'b00) begin
            if_main = `SDL_DEF_MAIN_B;
            if_swal = `SDL_DEF_SWAL_B;
        end else begin
            if_main = `SDL_DEF_MAIN_C;
            if_swal = `SDL_DEF_SWAL_C;
        end
    end

    wire [12:0] if_n = {if_main, 4'h0} + {9'h000, if_swal};
    reg  [12:0] if_cnt;
    reg  [8:0]  if_ref_cnt;
    wire        if_wrap  = ifvco_rise && (if_cnt + 13'h0001 >= if_n);
    wire        ifr_wrap = ref_rise && (if_ref_cnt + 9'h001 >= if_ref_n);

    // Both IF counters idle while the IF section is off
    always @(posedge MCLK) begin
        if (!RST_B || !if_on) begin
            if_cnt     <= 13'h0000;
            if_ref_cnt <= 9'h000;
        end else begin
            if (ifvco_rise) begin
                if_cnt <= if_wrap ? 13'h0000 : if_cnt + 13'h0001;
            end
            if (ref_rise) begin
                if_ref_cnt <= ifr_wrap ? 9'h000 : if_ref_cnt + 9'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock detector: compare every 64th reference and feedback edge
    reg  [5:0] ref_ph;
    reg  [5:0] fb_ph;
    reg        wait_ref;
    reg        wait_fb;
    reg  [7:0] err_cnt;
    reg  [2:0] good_cnt;
    reg        locked;
    wire       ref_tick = rf_on && ref_rise && (ref_ph == `SDL_CMP_LAST);
    wire       fb_tick  = rf_wrap && (fb_ph == `SDL_CMP_LAST);
    reg        cmp_done;
    reg        cmp_good;

    // Leading edge starts the error count, trailing edge ends it
    always @* begin
        cmp_done = 1'b0;
        cmp_good = 1'b0;
        if (wait_ref || wait_fb) begin
            if ((wait_ref && ref_tick) || (wait_fb && fb_tick)) begin
                cmp_done = 1'b1;
                cmp_good = (err_cnt <= `SDL_LOCK_WIN_CYC);
            end else if ((wait_ref && fb_tick) || (wait_fb && ref_tick)) begin
                cmp_done = 1'b1;                                     // Missed edge is a bad one
            end
        end else if (ref_tick && fb_tick) begin
            cmp_done = 1'b1;
            cmp_good = 1'b1;
        end
    end

    // Filter needs four uninterrupted good comparisons
    always @(posedge MCLK) begin
        if (!RST_B || !rf_on) begin
            ref_ph   <= 6'h00;
            fb_ph    <= 6'h00;
            wait_ref <= 1'b0;
            wait_fb  <= 1'b0;
            err_cnt  <= 8'h00;
            good_cnt <= 3'h0;
            locked   <= 1'b0;
        end else begin
            if (ref_rise) begin
                ref_ph <= ref_ph + 6'h01;
            end
            if (rf_wrap) begin
                fb_ph <= fb_ph + 6'h01;
            end
            if (err_cnt != 8'hff) begin
                err_cnt <= err_cnt + 8'h01;                          // Saturates on long errors
            end
            if (cmp_done && !cmp_good && (ref_tick != fb_tick)
                && ((wait_ref && fb_tick) || (wait_fb && ref_tick))) begin
                err_cnt <= 8'h01;                                    // Restart on the new edge
            end else if (cmp_done) begin
                wait_ref <= 1'b0;
                wait_fb  <= 1'b0;
            end else if (!wait_ref && !wait_fb && (ref_tick || fb_tick)) begin
                wait_ref <= fb_tick;
                wait_fb  <= ref_tick;
                err_cnt  <= 8'h01;
            end
            if (cmp_done && cmp_good) begin
                if (good_cnt != `SDL_LOCK_GOOD) begin
                    good_cnt <= good_cnt + 3'h1;
                end
                if (good_cnt + 3'h1 >= `SDL_LOCK_GOOD) begin
                    locked <= 1'b1;
                end
            end else if (cmp_done) begin
                good_cnt <= 3'h0;
                locked   <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Acquisition bandwidth control
    reg       rf_on_q;
    reg       locked_q;
    reg [8:0] wb_cnt;
    reg       wb_on;
    wire [2:0] dur_units = {1'b0, wideband_duration} + 3'h1;
    wire       wb_start  = wideband_enable && ((rf_on && !rf_on_q) || freq_loaded);

    // Wide loop from each retune until lock or the duration runs out
    always @(posedge MCLK) begin
        if (!RST_B) begin
            rf_on_q  <= 1'b0;
            locked_q <= 1'b0;
            wb_cnt   <= 9'h000;
            wb_on    <= 1'b0;
        end else begin
            rf_on_q  <= rf_on;
            locked_q <= locked;
            if (!rf_on) begin
                wb_on <= 1'b0;
            end else if (wb_start) begin
                wb_on  <= 1'b1;
                wb_cnt <= {dur_units, 6'h00};
            end else if (locked || (wb_cnt == 9'h000)) begin
                wb_on <= 1'b0;
            end else if (wb_on && ref_rise) begin
                wb_cnt <= wb_cnt - 9'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always @(posedge MCLK) begin
        if (!RST_B) begin
            RF_SECTION_ON      <= 1'b0;
            IF_SECTION_ON      <= 1'b0;
            RF_REF_PULSE       <= 1'b0;
            RF_FB_PULSE        <= 1'b0;
            IF_REF_PULSE       <= 1'b0;
            IF_FB_PULSE        <= 1'b0;
            LOCK_INDICATOR_OUT <= 1'b0;
            WIDEBAND_ACTIVE    <= 1'b0;
            WIDEBAND_CONTROL   <= 2'b00;
            SPUR_UPDATE        <= 1'b0;
            OUTPUT_LEVEL       <= 2'b00;
            IF_PUMP_CURRENT    <= 2'b00;
        end else begin
            RF_SECTION_ON      <= rf_on;
            IF_SECTION_ON      <= if_on;
            RF_REF_PULSE       <= rf_on & ref_rise;
            RF_FB_PULSE        <= rf_on & rf_wrap;
            IF_REF_PULSE       <= if_on & ifr_wrap;
            IF_FB_PULSE        <= if_on & if_wrap;
            LOCK_INDICATOR_OUT <= lock_en & rf_on & locked;
            WIDEBAND_ACTIVE    <= wb_on;
            WIDEBAND_CONTROL   <= wideband_control;
            // Once mode fires on lock rise, continuous on each locked compare
            if (!rf_on || spur_mode == `SDL_SPUR_OFF) begin
                SPUR_UPDATE <= 1'b0;
            end else if (spur_mode == `SDL_SPUR_ONCE) begin
                SPUR_UPDATE <= locked & ~locked_q;
            end else begin
                SPUR_UPDATE <= cmp_done & locked;
            end
            OUTPUT_LEVEL       <= cfg_word[`SDL_C_OUTLVL_HI:`SDL_C_OUTLVL_LO];
            IF_PUMP_CURRENT    <= ifcur_word[`SDL_IC_CUR_HI:`SDL_IC_CUR_LO];
        end
    end
endmodule // sdl_synth_ctrl
`default_nettype wire

// ---- sdl_host.sv ----
// Host model driving the three-wire programming link
`timescale 1ns/1ns
`default_nettype none
module sdl_host (
    // Pacing clock
    input  wire logic mclk,
    // Programming pins
    output var  logic ser_clk,
    output var  logic ser_data,
    output var  logic latch
);
    integer i;

    // Idle link, clock still between frames
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        latch = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One 24-bit word, MSB first, 125 ns bit time, strobe rise after the last bit
    task send(input logic [23:0] w);
        for (i = 23; i >= 0; i = i - 1) begin
            ser_data = w[i];
            #63 ser_clk = 1'b1;
            #62 ser_clk = 1'b0;
        end
        // Data line no longer held, so show it inverted
        ser_data = ~ser_data;
        #63 latch = 1'b1;
        #62 latch = 1'b0;
        repeat (8) @(negedge mclk);
    endtask
endmodule // sdl_host
`default_nettype wire

// ---- sdl_synth_ctrl_asserts.sv ----
// Port checker of the synthesizer control block
`timescale 1ns/1ns
`default_nettype none
module sdl_synth_ctrl_asserts (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_B,
    // Watched pins
    input wire logic CHIP_ENABLE,
    input wire logic RF_SECTION_ON,
    input wire logic IF_SECTION_ON,
    input wire logic RF_REF_PULSE,
    input wire logic RF_FB_PULSE,
    input wire logic IF_REF_PULSE,
    input wire logic IF_FB_PULSE,
    input wire logic LOCK_INDICATOR_OUT,
    input wire logic WIDEBAND_ACTIVE,
    input wire logic SPUR_UPDATE
);
    logic [8:0] refs_seen;

    // Reference pulses since the RF section came on, saturating; re-enabling the
    // lock output may show a lock already held, so only power-up restarts the count
    always @(posedge MCLK) begin
        if (!RST_B || !RF_SECTION_ON) refs_seen <= 9'h000;
        else if (RF_REF_PULSE && refs_seen != 9'h1ff) refs_seen <= refs_seen + 9'h001;
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    sequence ce_low_s; !CHIP_ENABLE [*5]; endsequence
    sequence rf_off_s; !RF_SECTION_ON [*2]; endsequence
    sequence lock_rise_s; $rose(LOCK_INDICATOR_OUT); endsequence

    ////////////////////////////////////////////////////////////////////////////////
    ce_gate_a: assert property (ce_low_s |-> !RF_SECTION_ON && !IF_SECTION_ON)
        else $error("section on while chip enable low");
    on_needs_ce_a: assert property ($rose(RF_SECTION_ON) || $rose(IF_SECTION_ON) |->
        $past(CHIP_ENABLE, 2) || $past(CHIP_ENABLE, 3) || $past(CHIP_ENABLE, 4))
        else $error("section came on without chip enable");
    lock_rf_a: assert property (rf_off_s |-> !LOCK_INDICATOR_OUT)
        else $error("lock shown with rf section off");
    // Four comparisons 64 references apart need three full gaps
    lock_settle_a: assert property (lock_rise_s |-> refs_seen >= 9'h0c0)
        else $error("lock rose too early");
    wide_end_a: assert property (lock_rise_s |-> ##[0:2] !WIDEBAND_ACTIVE)
        else $error("wide bandwidth kept after lock");
    rf_fb_gap_a: assert property (RF_FB_PULSE |=> !RF_FB_PULSE [*8])
        else $error("rf feedback pulses too close");
    if_fb_gap_a: assert property (IF_FB_PULSE |=> !IF_FB_PULSE [*8])
        else $error("if feedback pulses too close");
    if_ref_gap_a: assert property (IF_REF_PULSE |=> !IF_REF_PULSE [*8])
        else $error("if reference pulses too close");
    spur_pulse_a: assert property (SPUR_UPDATE |=> !SPUR_UPDATE)
        else $error("spur update longer than one cycle");
endmodule // sdl_synth_ctrl_asserts

bind sdl_synth_ctrl sdl_synth_ctrl_asserts i_sdl_synth_ctrl_asserts (
    .MCLK(MCLK), .RST_B(RST_B), .CHIP_ENABLE(CHIP_ENABLE), .RF_SECTION_ON(RF_SECTION_ON),
    .IF_SECTION_ON(IF_SECTION_ON), .RF_REF_PULSE(RF_REF_PULSE), .RF_FB_PULSE(RF_FB_PULSE),
    .IF_REF_PULSE(IF_REF_PULSE), .IF_FB_PULSE(IF_FB_PULSE),
    .LOCK_INDICATOR_OUT(LOCK_INDICATOR_OUT), .WIDEBAND_ACTIVE(WIDEBAND_ACTIVE),
    .SPUR_UPDATE(SPUR_UPDATE));
`default_nettype wire

// ---- test_sdl_synth_ctrl.sv ----
// Self-checking bench of the synthesizer control block
`timescale 1ns/1ns
`default_nettype none
module test_sdl_synth_ctrl;
    logic       mclk, rst_b, ce, rf_vco, ref_osc, if_vco, ser_clk, ser_data, latch;
    logic       vco_run = 1'b0, if_run = 1'b0;
    logic [1:0] lvl;
    wire        rf_on, if_on, rf_ref, rf_fb, if_ref, if_fb, lock, wide, spur;
    wire  [1:0] wctl, olvl, icur;
    integer     miscompares = 0, n_tests = 0, seed = 32'h3ae0;
    integer     ratio = 16, vcnt = 0, i, n, t;

    sdl_host i_sdl_host (.mclk(mclk), .ser_clk(ser_clk), .ser_data(ser_data), .latch(latch));
    sdl_synth_ctrl #(.VARIANT_CELL(1'b0)) i_sdl_synth_ctrl (
        .MCLK(mclk), .RST_B(rst_b), .SER_CLK(ser_clk), .SER_DATA(ser_data),
        .LATCH_STROBE(latch), .CHIP_ENABLE(ce), .REF_OSC_IN(ref_osc), .RF_VCO_IN(rf_vco),
        .IF_VCO_IN(if_vco), .RF_SECTION_ON(rf_on), .IF_SECTION_ON(if_on),
        .RF_REF_PULSE(rf_ref), .RF_FB_PULSE(rf_fb), .IF_REF_PULSE(if_ref),
        .IF_FB_PULSE(if_fb), .LOCK_INDICATOR_OUT(lock), .WIDEBAND_ACTIVE(wide),
        .WIDEBAND_CONTROL(wctl), .SPUR_UPDATE(spur), .OUTPUT_LEVEL(olvl),
        .IF_PUMP_CURRENT(icur));

    // 250 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // VCOs of six clocks; reference is one VCO period wide every ratio-th rise
    initial begin
        rf_vco = 1'b0;
        if_vco = 1'b0;
        ref_osc = 1'b0;
        #1;
        forever begin
            #12;
            if_vco = if_run & ~if_vco;
            rf_vco = vco_run & ~rf_vco;
            if (rf_vco) begin
                vcnt = (vcnt + 1) % ratio;
                ref_osc = (vcnt == 0);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task conclude;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Clock cycles covering k divider periods after the next pulse
    task span(input integer sel, input integer k, output integer c);
        integer m;
        integer g;
        m = -1;
        c = 0;
        g = 0;
        while (m < k && g < 40000) begin
            @(negedge mclk);
            g = g + 1;
            if (m >= 0) c = c + 1;
            if ((sel == 0 ? rf_fb : sel == 1 ? if_fb : if_ref) === 1'b1) m = m + 1;
        end
    endtask

    task wait_lock(input logic v, input integer lim, output integer c);
        c = 0;
        while (lock !== v && c < lim) begin
            @(negedge mclk);
            c = c + 1;
        end
    endtask

    // Frequency word, main count 2 and swallow 0 kept legal by the host
    function automatic logic [23:0] fword(input logic d, g, l, input logic [10:0] num);
        fword = {d, g, l, 1'b0, 4'h2, 3'h0, num, 2'b00};
    endfunction

    // Configuration word with continuous spur mode
    function automatic logic [23:0] cword(input logic [1:0] s, input logic o,
                                          input logic [1:0] v, input logic r, f);
        cword = {s, o, 8'h00, 2'b10, 5'h00, v, r, f, 2'b01};
    endfunction

    // Model: clocks in two feedback periods, carries from the numerator
    function automatic integer rf_exp(input integer m, input integer num, input integer den);
        rf_exp = 6 * (2 * (m * 2) + (2 * num) / den);
    endfunction

    // Watchdog sized from the longest expected run
    initial begin
        #390000;
        miscompares = miscompares + 1;
        conclude;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        ce = 1'b0;
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        // Every pin and bit combination of power gating
        for (i = 0; i < 8; i = i + 1) begin
            lvl = 2'($random(seed));
            ce = i[2];
            i_sdl_host.send(cword(2'b00, 1'b0, lvl, i[1], i[0]));
            chk(rf_on, i[2] & i[1]);
            chk(if_on, i[2] & i[0]);
            chk(olvl, lvl);
        end
        lvl = 2'($random(seed));
        i_sdl_host.send({2'b01, lvl, 1'b1, 16'h0000, 3'b011});
        chk(wctl, lvl);
        lvl = 2'($random(seed));
        i_sdl_host.send({lvl, 20'h00000, 2'b10});
        // Word with the reserved address is dropped
        i_sdl_host.send(24'hffffff);
        chk(icur, lvl);
        // RF divide ratios: both moduli, both fraction denominators
        for (i = 0; i < 4; i = i + 1) begin
            n = i < 2 ? 0 : (i == 2 ? 960 : 984);
            i_sdl_host.send(cword(2'b00, i == 3, 2'b00, 1'b1, 1'b1));
            i_sdl_host.send(fword(1'b0, i == 1, 1'b0, n[10:0]));
            // VCO starts only once a legal main count is held
            vco_run = 1'b1;
            span(0, 2, t);
            chk(t, rf_exp(i == 1 ? 6 : 8, n, i == 3 ? 1968 : 1920));
        end
        // IF feedback and reference dividers programmed, then default feedback divider
        i_sdl_host.send({7'h00, 4'h3, 9'h004, 4'b0111});
        if_run = 1'b1;
        i_sdl_host.send({10'h000, 9'h005, 5'b01111});
        span(1, 1, t);
        chk(t, 6 * (16 * 4 + 3));
        span(2, 1, t);
        chk(t, 96 * 5);
        i_sdl_host.send(cword(2'b00, 1'b0, 2'b00, 1'b1, 1'b1));
        i_sdl_host.send(fword(1'b1, 1'b0, 1'b0, 11'h000));
        span(1, 1, t);
        chk(t, 6 * (16 * 88 + 15));
        if_run = 1'b0;
        // Lock: restart with reference edges on feedback edges
        i_sdl_host.send(cword(2'b00, 1'b0, 2'b00, 1'b0, 1'b0));
        vco_run = 1'b0;
        repeat (8) @(negedge mclk);
        vcnt = 0;
        i_sdl_host.send(fword(1'b0, 1'b0, 1'b1, 11'h000));
        i_sdl_host.send(cword(2'b00, 1'b0, 2'b00, 1'b1, 1'b0));
        chk(wide, 1'b1);
        vco_run = 1'b1;
        wait_lock(1'b1, 40000, t);
        chk(lock, 1'b1);
        chk(t >= 192 * 96, 1'b1);
        // Continuous spur mode updates at each locked comparison
        n = 0;
        while (spur !== 1'b1 && n < 7000) begin
            @(negedge mclk);
            n = n + 1;
        end
        chk(spur, 1'b1);
        i_sdl_host.send(fword(1'b0, 1'b0, 1'b0, 11'h000));
        chk(lock, 1'b0);
        i_sdl_host.send(fword(1'b0, 1'b0, 1'b1, 11'h000));
        wait_lock(1'b1, 40000, t);
        chk(lock, 1'b1);
        // Reference one VCO rise slower: next comparison is bad
        ratio = 17;
        wait_lock(1'b0, 8000, t);
        chk(lock, 1'b0);
        i_sdl_host.send(cword(2'b00, 1'b0, 2'b00, 1'b0, 1'b0));
        chk(lock, 1'b0);
        conclude;
    end
endmodule // test_sdl_synth_ctrl
`default_nettype wire
